//--- rtl/ctrl_page_pkg.sv
// constants and carriers of the reader control and status register page
//
// Summary of operation
// - control bit 5 selects light sleep, clock runs
// - control bit 4 selects deep sleep, clock stops
// - bit 3 cipher on; only auth step two sets
// - writing 1 to bit 2 halts countdown
// - writing 1 to bit 1 starts countdown, unless bit 2 is written 1 too
// - writing 1 to bit 0 purges queue state
// - strobe bits always read back zero
// - error register reports last command; resets 40h
// - bit 6 key format fault, cleared at key load
// - bit 5 nvm rights fault, cleared at nvm command
// - bit 4 set on write into full queue
// - bit 3 set on checksum failure when checking
// - bit 2 set on bad start of frame
// - bit 1 set on parity failure
// - bit 0 set on bit collision
// - bits 3..0 cleared in receiver preparation state
// - collision position holds first clash index
// - countdown register shows live timer count
// - running timer decrements, requests at zero
package ctrl_page_pkg;
	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [5:0] idx_control_flags      = 6'h09;
	localparam logic [5:0] idx_error_flags        = 6'h0a;
	localparam logic [5:0] idx_collision_position = 6'h0b;
	localparam logic [5:0] idx_countdown_count    = 6'h0c;
	localparam logic [5:0] idx_irq_status         = 6'h10;
	localparam logic [5:0] idx_irq_mask           = 6'h11;
	localparam logic [5:0] idx_countdown_reload   = 6'h12;
	// ----------------------------------------------------------------
	// control bit positions
	// ----------------------------------------------------------------
	localparam int ctl_light_sleep = 5;
	localparam int ctl_full_sleep  = 4;
	localparam int ctl_cipher      = 3;
	localparam int ctl_halt        = 2;
	localparam int ctl_go          = 1;
	localparam int ctl_purge       = 0;
	// ----------------------------------------------------------------
	// error bit positions
	// ----------------------------------------------------------------
	localparam int err_key      = 6;
	localparam int err_rights   = 5;
	localparam int err_overrun  = 4;
	localparam int err_checksum = 3;
	localparam int err_sof      = 2;
	localparam int err_parity   = 1;
	localparam int err_clash    = 0;
	// ----------------------------------------------------------------
	// interrupt bit positions
	// ----------------------------------------------------------------
	localparam int irq_zero    = 0;
	localparam int irq_overrun = 1;
	localparam int irq_rx      = 2;
	localparam int irq_cmd     = 3;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] rst_control  = 8'h00;
	localparam logic [7:0] rst_error    = 8'h40;
	localparam logic [7:0] rst_clash    = 8'h00;
	localparam logic [7:0] rst_count    = 8'h00;
	localparam logic [7:0] rst_reload   = 8'hff;
	localparam logic [3:0] rst_irq      = 4'h0;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       prepare;
		logic       checksum_bad;
		logic       sof_bad;
		logic       parity_bad;
		logic       clash;
		logic [7:0] clash_index;
	} rx_events_t;
	typedef struct packed {
		logic key_load_start;
		logic key_format_bad;
		logic nvm_cmd_start;
		logic nvm_rights_bad;
		logic auth_step_two_ok;
	} cmd_events_t;
endpackage : ctrl_page_pkg

//--- rtl/reader_control_status_page.sv
// control and status register page with countdown timer, apb slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module reader_control_status_page #(
	parameter int addr_w = 8
) (
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	input  wire logic                      clk_en,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [addr_w-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire ctrl_page_pkg::rx_events_t rx_evt,
	input  wire ctrl_page_pkg::cmd_events_t cmd_evt,
	input  wire logic                      rx_checksum_check_on,
	input  wire logic                      queue_write_try,
	input  wire logic                      queue_full,
	input  wire logic                      countdown_tick,
	output logic                           light_sleep,
	output logic                           full_sleep,
	output logic                           cipher_active,
	output logic                           queue_purge,
	output logic                           countdown_running,
	output logic                           countdown_zero_request,
	output logic                           irq
);
	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (addr_w < 8) begin : g_bad_addr
		$error("addr_w must be at least 8");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0] sleep_r;
	logic       cipher_r;
	logic [7:0] error_r;
	logic [7:0] clash_pos_r;
	logic [7:0] count_r;
	logic [7:0] reload_r;
	logic       running_r;
	logic       purge_r;
	logic       zero_req_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic [7:0] rdata_nxt;
	logic       hit;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic       acc;
	logic       wr;
	logic       rd;
	logic [5:0] idx;
	logic       aligned;
	logic       hi_zero;

	assign acc     = psel && penable;
	assign wr      = acc && pwrite && clk_en;
	assign rd      = acc && !pwrite && clk_en;
	assign idx     = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign hi_zero = (paddr >> 8) == '0;
	assign pready  = clk_en;

	logic wr_ctl;
	logic wr_mask;
	logic wr_reload;
	logic rd_stat;

	assign wr_ctl    = wr && hit && (idx == ctrl_page_pkg::idx_control_flags);
	assign wr_mask   = wr && hit && (idx == ctrl_page_pkg::idx_irq_mask);
	assign wr_reload = wr && hit
		&& (idx == ctrl_page_pkg::idx_countdown_reload);
	assign rd_stat   = rd && hit && (idx == ctrl_page_pkg::idx_irq_status);

	logic halt_s;
	logic go_s;
	logic purge_s;

	assign halt_s  = wr_ctl && pwdata[ctrl_page_pkg::ctl_halt];
	assign go_s    = wr_ctl && pwdata[ctrl_page_pkg::ctl_go];
	assign purge_s = wr_ctl && pwdata[ctrl_page_pkg::ctl_purge];

	always_comb begin
		rdata_nxt = 8'h00;
		hit       = aligned && hi_zero;
		if (idx == ctrl_page_pkg::idx_control_flags) begin
			// strobes read as zero
			rdata_nxt = {2'b00, sleep_r, cipher_r, 3'b000};
		end else if (idx == ctrl_page_pkg::idx_error_flags) begin
			rdata_nxt = error_r;
		end else if (idx == ctrl_page_pkg::idx_collision_position) begin
			rdata_nxt = clash_pos_r;
		end else if (idx == ctrl_page_pkg::idx_countdown_count) begin
			rdata_nxt = count_r;
		end else if (idx == ctrl_page_pkg::idx_irq_status) begin
			rdata_nxt = {4'h0, irq_stat_r};
		end else if (idx == ctrl_page_pkg::idx_irq_mask) begin
			rdata_nxt = {4'h0, irq_mask_r};
		end else if (idx == ctrl_page_pkg::idx_countdown_reload) begin
			rdata_nxt = reload_r;
		end else begin
			hit = 1'b0;
		end
	end

	assign prdata  = (acc && !pwrite && hit) ? {24'h0, rdata_nxt} : 32'h0;
	assign pslverr = acc && !hit;

	// ----------------------------------------------------------------
	// control flags
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sleep_r <= ctrl_page_pkg::rst_control[5:4];
		end else if (wr_ctl) begin
			sleep_r <= pwdata[5:4];
		end
	end

	assign light_sleep = sleep_r[ctrl_page_pkg::ctl_light_sleep - 4];
	assign full_sleep  = sleep_r[ctrl_page_pkg::ctl_full_sleep - 4];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cipher_r <= ctrl_page_pkg::rst_control[3];
		end else if (clk_en) begin
			if (cmd_evt.auth_step_two_ok) begin
				cipher_r <= 1'b1;
			end else if (wr_ctl && !pwdata[ctrl_page_pkg::ctl_cipher]) begin
				cipher_r <= 1'b0;
			end
		end
	end

	assign cipher_active = cipher_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			purge_r <= 1'b0;
		end else if (clk_en) begin
			purge_r <= purge_s;
		end
	end

	assign queue_purge = purge_r;

	// ----------------------------------------------------------------
	// countdown timer
	// ----------------------------------------------------------------
	logic zero_evt;

	assign zero_evt = running_r && countdown_tick && !halt_s && !go_s
		&& (count_r <= 8'h01);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			running_r <= 1'b0;
			count_r   <= ctrl_page_pkg::rst_count;
		end else if (clk_en) begin
			if (halt_s) begin
				running_r <= 1'b0;
			end else if (go_s) begin
				running_r <= 1'b1;
				count_r   <= reload_r;
			end else if (zero_evt) begin
				running_r <= 1'b0;
				count_r   <= 8'h00;
			end else if (running_r && countdown_tick) begin
				count_r <= count_r - 8'h01;
			end
		end
	end

	assign countdown_running = running_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reload_r <= ctrl_page_pkg::rst_reload;
		end else if (wr_reload) begin
			reload_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			zero_req_r <= 1'b0;
		end else if (clk_en) begin
			if (zero_evt) begin
				zero_req_r <= 1'b1;
			end else if (go_s) begin
				zero_req_r <= 1'b0;
			end
		end
	end

	assign countdown_zero_request = zero_req_r;

	// ----------------------------------------------------------------
	// error flags
	// ----------------------------------------------------------------
	logic       overrun_evt;
	logic [3:0] rx_set;

	assign overrun_evt = queue_write_try && queue_full;
	assign rx_set = {rx_evt.checksum_bad && rx_checksum_check_on,
		rx_evt.sof_bad, rx_evt.parity_bad, rx_evt.clash};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			error_r <= ctrl_page_pkg::rst_error;
		end else if (clk_en) begin
			error_r[7] <= 1'b0;
			if (cmd_evt.key_format_bad) begin
				error_r[ctrl_page_pkg::err_key] <= 1'b1;
			end else if (cmd_evt.key_load_start) begin
				error_r[ctrl_page_pkg::err_key] <= 1'b0;
			end
			if (cmd_evt.nvm_rights_bad) begin
				error_r[ctrl_page_pkg::err_rights] <= 1'b1;
			end else if (cmd_evt.nvm_cmd_start) begin
				error_r[ctrl_page_pkg::err_rights] <= 1'b0;
			end
			if (overrun_evt) begin
				error_r[ctrl_page_pkg::err_overrun] <= 1'b1;
			end else if (purge_s) begin
				error_r[ctrl_page_pkg::err_overrun] <= 1'b0;
			end
			// set wins over preparation clear
			for (int i = 0; i < 4; i++) begin
				if (rx_set[i]) begin
					error_r[i] <= 1'b1;
				end else if (rx_evt.prepare) begin
					error_r[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// first collision position
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clash_pos_r <= ctrl_page_pkg::rst_clash;
		end else if (clk_en && rx_evt.clash) begin
			if (!error_r[ctrl_page_pkg::err_clash] || rx_evt.prepare) begin
				clash_pos_r <= rx_evt.clash_index;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic [3:0] irq_set;

	assign irq_set = {cmd_evt.key_format_bad || cmd_evt.nvm_rights_bad,
		|rx_set, overrun_evt, zero_evt};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_stat_r <= ctrl_page_pkg::rst_irq;
		end else if (clk_en) begin
			if (rd_stat) begin
				irq_stat_r <= irq_set;
			end else begin
				irq_stat_r <= irq_stat_r | irq_set;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_mask_r <= ctrl_page_pkg::rst_irq;
		end else if (wr_mask) begin
			irq_mask_r <= pwdata[3:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	light_sleep_a: assert property (
		wr_ctl |=> light_sleep == $past(pwdata[5]))
		else $error("light sleep does not follow write");
	full_sleep_a: assert property (
		wr_ctl |=> full_sleep == $past(pwdata[4]))
		else $error("deep sleep does not follow write");
	cipher_set_a: assert property (
		$rose(cipher_active) |-> $past(cmd_evt.auth_step_two_ok))
		else $error("cipher switched on without auth step two");
	timer_halt_a: assert property (
		halt_s |=> !countdown_running)
		else $error("timer not halted");
	timer_go_a: assert property (
		go_s && !halt_s |=> countdown_running && count_r == $past(reload_r))
		else $error("timer not started from reload");
	queue_purge_a: assert property (
		purge_s && !overrun_evt |=> queue_purge
		&& !error_r[ctrl_page_pkg::err_overrun])
		else $error("purge did not clear overrun");
	strobe_read_a: assert property (
		rd && idx == ctrl_page_pkg::idx_control_flags |-> prdata[2:0] == 3'b000)
		else $error("strobe bits read nonzero");
	err_reserved_a: assert property (
		clk_en |=> !error_r[7])
		else $error("reserved error bit set");
	key_fault_a: assert property (
		clk_en && cmd_evt.key_format_bad |=> error_r[6])
		else $error("key fault not flagged");
	rights_fault_a: assert property (
		clk_en && cmd_evt.nvm_cmd_start && !cmd_evt.nvm_rights_bad
		|=> !error_r[5])
		else $error("rights fault not cleared");
	overrun_flag_a: assert property (
		clk_en && overrun_evt |=> error_r[4] && irq_stat_r[1])
		else $error("overrun not flagged");
	checksum_gate_a: assert property (
		clk_en && rx_evt.prepare && !rx_checksum_check_on |=> !error_r[3])
		else $error("checksum fault without checking");
	sof_fault_a: assert property (
		clk_en && rx_evt.sof_bad |=> error_r[2])
		else $error("frame start fault not flagged");
	parity_fault_a: assert property (
		clk_en && rx_evt.parity_bad |=> error_r[1])
		else $error("parity fault not flagged");
	clash_fault_a: assert property (
		clk_en && rx_evt.clash |=> error_r[0])
		else $error("collision not flagged");
	rx_prepare_a: assert property (
		clk_en && rx_evt.prepare && rx_set == 4'h0 |=> error_r[3:0] == 4'h0)
		else $error("preparation did not clear receive faults");
	first_clash_a: assert property (
		clk_en && rx_evt.clash && !error_r[0] |=>
		clash_pos_r == $past(rx_evt.clash_index))
		else $error("first collision index not held");
	count_shown_a: assert property (
		rd && hit && idx == ctrl_page_pkg::idx_countdown_count |->
		prdata[7:0] == count_r)
		else $error("count not shown");
	zero_request_a: assert property (
		clk_en && running_r && countdown_tick && count_r == 8'h01
		&& !halt_s && !go_s |=> countdown_zero_request && count_r == 8'h00
		&& !countdown_running)
		else $error("zero not reached or not requested");

	timer_zero_c: cover property (zero_evt ##1 irq);
	purge_c: cover property (purge_s && error_r[4]);
	auth_c: cover property ($rose(cipher_active));
	clash_c: cover property (rx_evt.clash ##[1:8] rx_evt.clash);
endmodule : reader_control_status_page

//--- bench/host_apb_model.sv
// host processor model issuing register transfers over apb
`timescale 1ns/1ns
module host_apb_model (
	input  wire logic        ref_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// ----------------------------------------------------------------
	// one transfer: setup, access until pready, then release
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] rd, output logic er);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~{24'h0, d};
	endtask : xfer
endmodule : host_apb_model

//--- bench/tb.sv
// self-checking testbench of the control and status register page
`timescale 1ns/1ns
module tb;
	logic                       ref_clk, srst, clk_en, pwrite, psel;
	logic                       penable, pready, pslverr, chk_on, qw, qf;
	logic                       tick, ls, fs, ca, qp, run, zr, irq;
	logic [7:0]                 paddr;
	logic [31:0]                pwdata, prdata;
	ctrl_page_pkg::rx_events_t  rx_evt;
	ctrl_page_pkg::cmd_events_t cmd_evt;
	int                         mismatches, total_checks;
	logic [31:0]                rdv;
	logic                       erv;
	reader_control_status_page reader_control_status_page_inst (
		.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_evt(rx_evt), .cmd_evt(cmd_evt),
		.rx_checksum_check_on(chk_on), .queue_write_try(qw),
		.queue_full(qf), .countdown_tick(tick), .light_sleep(ls),
		.full_sleep(fs), .cipher_active(ca), .queue_purge(qp),
		.countdown_running(run), .countdown_zero_request(zr), .irq(irq));
	host_apb_model host_apb_model_inst (
		.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ----------------------------------------------------------------
	// compare, bus and stimulus helpers
	// ----------------------------------------------------------------
	task automatic chk_reg(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg
	task automatic chk_pin(input string n, input logic e, g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask : chk_pin
	task automatic wr(input logic [7:0] a, d);
		host_apb_model_inst.xfer(1'b1, a, d, rdv, erv);
		#1;
	endtask : wr
	task automatic rd_chk(input string n, input logic [7:0] a, e);
		host_apb_model_inst.xfer(1'b0, a, 8'h00, rdv, erv);
		chk_reg(n, {24'h0, e}, rdv);
		#1;
	endtask : rd_chk
	task automatic evt(input logic [12:0] r, input logic [4:0] c,
		input logic q);
		@(posedge ref_clk);
		rx_evt <= r;
		cmd_evt <= c;
		qw <= q;
		@(posedge ref_clk);
		rx_evt <= '0;
		cmd_evt <= '0;
		qw <= 1'b0;
	endtask : evt
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			tick <= 1'b1;
			@(posedge ref_clk);
			tick <= 1'b0;
		end
	endtask : ticks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd_chk("control", 8'h24, 8'h00);
		rd_chk("error", 8'h28, 8'h40);
		rd_chk("collision", 8'h2c, 8'h00);
		rd_chk("count", 8'h30, 8'h00);
	endtask : t_reset
	task automatic t_control;
		wr(8'h24, 8'h3f);
		chk_pin("purge", 1'b1, qp);
		chk_pin("light", 1'b1, ls);
		chk_pin("full", 1'b1, fs);
		chk_pin("cipher", 1'b0, ca);
		chk_pin("running", 1'b0, run);
		rd_chk("control", 8'h24, 8'h30);
		evt(13'h0, 5'h01, 1'b0);
		rd_chk("control", 8'h24, 8'h38);
		wr(8'h24, 8'h00);
		chk_pin("cipher", 1'b0, ca);
	endtask : t_control
	task automatic t_timer;
		wr(8'h48, 8'h03);
		wr(8'h24, 8'h02);
		chk_pin("running", 1'b1, run);
		rd_chk("count", 8'h30, 8'h03);
		ticks(2);
		rd_chk("count", 8'h30, 8'h01);
		ticks(1);
		#1;
		chk_pin("running", 1'b0, run);
		chk_pin("zero", 1'b1, zr);
		rd_chk("count", 8'h30, 8'h00);
		wr(8'h44, 8'h01);
		chk_pin("irq", 1'b1, irq);
		rd_chk("status", 8'h40, 8'h01);
		chk_pin("irq", 1'b0, irq);
		wr(8'h24, 8'h02);
		chk_pin("zero", 1'b0, zr);
		ticks(1);
		wr(8'h24, 8'h04);
		chk_pin("running", 1'b0, run);
		ticks(1);
		rd_chk("count", 8'h30, 8'h02);
	endtask : t_timer
	task automatic t_errors;
		logic [12:0] r[12] = '{13'h0, 13'h0, 13'h0, 13'h0, 13'h0, 13'h800,
			13'h800, 13'h400, 13'h200, 13'h105, 13'h107, 13'h1000};
		logic [4:0]  c[12] = '{5'h10, 5'h08, 5'h02, 5'h04, 5'h0, 5'h0,
			5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0};
		logic [7:0]  e[12] = '{8'h00, 8'h40, 8'h60, 8'h40, 8'h50, 8'h50,
			8'h58, 8'h5c, 8'h5e, 8'h5f, 8'h5f, 8'h50};
		for (int i = 0; i < 12; i++) begin
			@(posedge ref_clk);
			chk_on <= (i >= 6);
			evt(r[i], c[i], i == 4);
			rd_chk("error", 8'h28, e[i]);
			if (i >= 9)
				rd_chk("collision", 8'h2c, 8'h05);
		end
		chk_pin("irq", 1'b0, irq);
		rd_chk("status", 8'h40, 8'h0e);
		wr(8'h24, 8'h01);
		rd_chk("error", 8'h28, 8'h40);
	endtask : t_errors
	task automatic t_unmapped;
		host_apb_model_inst.xfer(1'b0, 8'h3c, 8'h00, rdv, erv);
		chk_pin("slverr", 1'b1, erv);
		chk_reg("unmapped", 32'h0, rdv);
		host_apb_model_inst.xfer(1'b1, 8'h29, 8'h00, rdv, erv);
		chk_pin("slverr", 1'b1, erv);
		rd_chk("error", 8'h28, 8'h40);
	endtask : t_unmapped
	task automatic t_freeze;
		wr(8'h24, 8'h02);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		tick <= 1'b1;
		rx_evt <= 13'h0104;
		fork
			rd_chk("count", 8'h30, 8'h03);
			begin
				repeat (4) @(posedge ref_clk);
				clk_en <= 1'b1;
				tick <= 1'b0;
				rx_evt <= '0;
			end
		join
		chk_pin("running", 1'b1, run);
		rd_chk("error", 8'h28, 8'h40);
		rd_chk("collision", 8'h2c, 8'h05);
	endtask : t_freeze
	// ----------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#100000;
		mismatches++;
		report_and_stop;
	end
	initial begin
		mismatches = 0;
		total_checks = 0;
		srst = 1'b1;
		clk_en = 1'b1;
		chk_on = 1'b0;
		qw = 1'b0;
		qf = 1'b1;
		tick = 1'b0;
		rx_evt = '0;
		cmd_evt = '0;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset;
		t_control;
		t_timer;
		t_errors;
		t_unmapped;
		t_freeze;
		report_and_stop;
	end
endmodule : tb
